// ### include/ext_volt_change_enable_params.svh
// Operation
// - Writing go bit starts single conversion
// - Single completion stores result, raises interrupt
// - No background conversions until interval programmed
// - Interval field selects background conversion period
// - Background result beyond delta signals change
// - Change sets power event change flag
// - Change flag reaches interrupt only when enabled
// - Full power: single and background conversions
// - Battery active: single only, background suppressed
// - Sleep: background conversions only
// - Result register updates only with interrupt
// - Interrupt on change or single completion
// - Converter interrupt has no pollable flag
// - Result is unsigned eight bit code
// - One code step is 15.3 mV
`ifndef EXT_VOLT_CHANGE_ENABLE_PARAMS_SVH
`define EXT_VOLT_CHANGE_ENABLE_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define EXT_VOLT_CHANGE_ENABLE_ADDR_START   8'hd8
`define EXT_VOLT_CHANGE_ENABLE_ADDR_ENABLE  8'hec
`define EXT_VOLT_CHANGE_ENABLE_ADDR_RESULT  8'hef
`define EXT_VOLT_CHANGE_ENABLE_ADDR_DELTA   8'hf3
`define EXT_VOLT_CHANGE_ENABLE_ADDR_FLAGS   8'hf8
`define EXT_VOLT_CHANGE_ENABLE_ADDR_PERIOD  8'hf9

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define EXT_VOLT_CHANGE_ENABLE_GO_BIT       2
`define EXT_VOLT_CHANGE_ENABLE_EN_BIT       3
`define EXT_VOLT_CHANGE_ENABLE_FLAG_BIT     3
`define EXT_VOLT_CHANGE_ENABLE_PER_LSB      4
`define EXT_VOLT_CHANGE_ENABLE_PER_MSB      5
`define EXT_VOLT_CHANGE_ENABLE_DELTA_MSB    2
`define EXT_VOLT_CHANGE_ENABLE_RESET_BYTE   8'h00
`define EXT_VOLT_CHANGE_ENABLE_RESET_PER    2'h0
`define EXT_VOLT_CHANGE_ENABLE_RESET_DELTA  3'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define EXT_VOLT_CHANGE_ENABLE_CLK_KHZ      125000
`define EXT_VOLT_CHANGE_ENABLE_PER1_MS      1000
`define EXT_VOLT_CHANGE_ENABLE_PER2_MS      2000
`define EXT_VOLT_CHANGE_ENABLE_PER3_MS      4000
`define EXT_VOLT_CHANGE_ENABLE_LSB_UV       15300

`endif

// ### include/ext_volt_change_enable_pkg.sv
package ext_volt_change_enable_pkg;

    // Register access from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ext_volt_change_enable_sfr_req_t;

    // Power state, one bit per state
    typedef struct packed {
        logic full;
        logic battery;
        logic sleep;
    } ext_volt_change_enable_pwr_t;

    // Unsigned conversion code
    typedef logic [7:0] ext_volt_change_enable_code_t;

    typedef enum logic [2:0] {
        EXT_VOLT_CHANGE_ENABLE_IDLE = 3'b001,
        EXT_VOLT_CHANGE_ENABLE_CONV = 3'b010,
        EXT_VOLT_CHANGE_ENABLE_DROP = 3'b100
    } ext_volt_change_enable_state_t;

endpackage : ext_volt_change_enable_pkg

// ### rtl/ext_volt_change_enable_tick.sv
`timescale 1ns/1ps
`include "ext_volt_change_enable_params.svh"

module ext_volt_change_enable_tick
#(
    parameter logic [31:0] PER1_CYC = 32'd1,
    parameter logic [31:0] PER2_CYC = 32'd2,
    parameter logic [31:0] PER3_CYC = 32'd4
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Control
    input  wire logic [1:0] sel,
    // Event
    output logic            tick
);

    logic [31:0] cnt_q;
    logic [1:0]  sel_q;
    logic [31:0] limit;
    wire         restart = (sel != sel_q);
    wire         wrap    = (cnt_q >= limit - 32'd1);

    assign limit = (sel == 2'd1) ? PER1_CYC :
                   (sel == 2'd2) ? PER2_CYC : PER3_CYC;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 32'h0;
            sel_q <= `EXT_VOLT_CHANGE_ENABLE_RESET_PER;
            tick  <= 1'b0;
        end
        else if (ce)
        begin
            sel_q <= sel;
            if (sel == 2'd0 || restart)
            begin
                cnt_q <= 32'h0;
                tick  <= 1'b0;
            end
            else
            begin
                cnt_q <= wrap ? 32'h0 : cnt_q + 32'd1;
                tick  <= wrap;
            end
        end
    end

endmodule : ext_volt_change_enable_tick

// ### rtl/ext_volt_change_enable_ctrl.sv
`timescale 1ns/1ps
`include "ext_volt_change_enable_params.svh"

module ext_volt_change_enable_ctrl
    import ext_volt_change_enable_pkg::*;
#(
    parameter logic [31:0] PER1_CYC = 32'(`EXT_VOLT_CHANGE_ENABLE_PER1_MS * `EXT_VOLT_CHANGE_ENABLE_CLK_KHZ),
    parameter logic [31:0] PER2_CYC = 32'(`EXT_VOLT_CHANGE_ENABLE_PER2_MS * `EXT_VOLT_CHANGE_ENABLE_CLK_KHZ),
    parameter logic [31:0] PER3_CYC = 32'(`EXT_VOLT_CHANGE_ENABLE_PER3_MS * `EXT_VOLT_CHANGE_ENABLE_CLK_KHZ)
)
(
    // Clock and reset
    input  wire logic           core_clk,
    input  wire logic           reset_n,
    input  wire logic           clk_en,
    // Register access
    input  wire ext_volt_change_enable_sfr_req_t sfr_req,
    output logic [7:0]          sfr_rdata,
    // Power state
    input  wire ext_volt_change_enable_pwr_t     pwr_mode_in,
    // Converter handshake
    output logic                conv_req,
    input  wire logic           conv_done_in,
    input  wire ext_volt_change_enable_code_t    conv_data_in,
    // Interrupts
    output logic                adc_irq,
    output logic                psm_irq
);

    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else if (clk_en)
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [11:0] sync_meta_q;
    logic [11:0] sync_q;
    wire  [11:0] sync_in = {pwr_mode_in, conv_done_in, conv_data_in};

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sync_meta_q <= 12'h000;
            sync_q      <= 12'h000;
        end
        else if (clk_en)
        begin
            sync_meta_q <= sync_in;
            sync_q      <= sync_meta_q;
        end
    end

    ext_volt_change_enable_pwr_t  pwr_s;
    logic        done_s;
    ext_volt_change_enable_code_t data_s;

    assign pwr_s  = ext_volt_change_enable_pwr_t'(sync_q[11:9]);
    assign done_s = sync_q[8];
    assign data_s = sync_q[7:0];

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic        go_q;
    logic        en_q;
    logic        flag_q;
    logic [2:0]  delta_q;
    logic [1:0]  per_q;
    ext_volt_change_enable_code_t result_q;
    ext_volt_change_enable_code_t ref_q;

    wire wr_start  = sfr_req.wr && (sfr_req.addr == `EXT_VOLT_CHANGE_ENABLE_ADDR_START);
    wire wr_enable = sfr_req.wr && (sfr_req.addr == `EXT_VOLT_CHANGE_ENABLE_ADDR_ENABLE);
    wire wr_delta  = sfr_req.wr && (sfr_req.addr == `EXT_VOLT_CHANGE_ENABLE_ADDR_DELTA);
    wire wr_flags  = sfr_req.wr && (sfr_req.addr == `EXT_VOLT_CHANGE_ENABLE_ADDR_FLAGS);
    wire wr_period = sfr_req.wr && (sfr_req.addr == `EXT_VOLT_CHANGE_ENABLE_ADDR_PERIOD);

    // ---------------------------------------------------------------
    // Power state gating
    // ---------------------------------------------------------------
    wire single_ok = pwr_s.full || pwr_s.battery;
    wire bg_ok     = pwr_s.full || pwr_s.sleep;

    // ---------------------------------------------------------------
    // Background interval
    // ---------------------------------------------------------------
    logic bg_tick;

    ext_volt_change_enable_tick #(
        .PER1_CYC (PER1_CYC),
        .PER2_CYC (PER2_CYC),
        .PER3_CYC (PER3_CYC)
    ) u_tick (
        .clk   (core_clk),
        .rst_n (rst_n_q),
        .ce    (clk_en),
        .sel   (per_q),
        .tick  (bg_tick)
    );

    // ---------------------------------------------------------------
    // Conversion sequencer
    // ---------------------------------------------------------------
    ext_volt_change_enable_state_t state_q;
    ext_volt_change_enable_state_t state_d;
    logic         single_q;
    logic         single_d;
    logic         bg_pend_q;

    wire start_single = go_q && single_ok;
    wire start_bg     = bg_pend_q && bg_ok;
    wire done_evt     = (state_q == EXT_VOLT_CHANGE_ENABLE_CONV) && done_s;

    always_comb
    begin
        state_d  = state_q;
        single_d = single_q;
        unique case (state_q)
            EXT_VOLT_CHANGE_ENABLE_IDLE:
            begin
                if (start_single)
                begin
                    state_d  = EXT_VOLT_CHANGE_ENABLE_CONV;
                    single_d = 1'b1;
                end
                else if (start_bg)
                begin
                    state_d  = EXT_VOLT_CHANGE_ENABLE_CONV;
                    single_d = 1'b0;
                end
            end
            EXT_VOLT_CHANGE_ENABLE_CONV:
            begin
                if (done_s)
                begin
                    state_d = EXT_VOLT_CHANGE_ENABLE_DROP;
                end
            end
            EXT_VOLT_CHANGE_ENABLE_DROP:
            begin
                if (!done_s)
                begin
                    state_d = EXT_VOLT_CHANGE_ENABLE_IDLE;
                end
            end
            default:
            begin
                state_d  = EXT_VOLT_CHANGE_ENABLE_IDLE;
                single_d = 1'b0;
            end
        endcase
    end

    wire bg_start_evt = (state_q == EXT_VOLT_CHANGE_ENABLE_IDLE) && !start_single && start_bg;

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q   <= EXT_VOLT_CHANGE_ENABLE_IDLE;
            single_q  <= 1'b0;
            conv_req  <= 1'b0;
            bg_pend_q <= 1'b0;
        end
        else if (clk_en)
        begin
            state_q   <= state_d;
            single_q  <= single_d;
            conv_req  <= (state_d == EXT_VOLT_CHANGE_ENABLE_CONV);
            bg_pend_q <= bg_ok
                         && (bg_tick || (bg_pend_q && !bg_start_evt));
        end
    end

    // ---------------------------------------------------------------
    // Result compare
    // ---------------------------------------------------------------
    ext_volt_change_enable_code_t abs_diff;
    logic        change;
    logic        irq_evt;

    assign abs_diff = (data_s >= ref_q) ? data_s - ref_q
                                        : ref_q - data_s;
    assign change   = abs_diff > {5'h00, delta_q};
    assign irq_evt  = done_evt && (single_q || change);

    wire flag_set = done_evt && !single_q && change;
    wire go_clear = done_evt && single_q;

    // ---------------------------------------------------------------
    // Register updates
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            go_q    <= 1'b0;
            en_q    <= 1'b0;
            delta_q <= `EXT_VOLT_CHANGE_ENABLE_RESET_DELTA;
            per_q   <= `EXT_VOLT_CHANGE_ENABLE_RESET_PER;
        end
        else if (clk_en)
        begin
            if (wr_start)
            begin
                go_q <= sfr_req.wdata[`EXT_VOLT_CHANGE_ENABLE_GO_BIT];
            end
            else if (go_clear)
            begin
                go_q <= 1'b0;
            end
            if (wr_enable)
            begin
                en_q <= sfr_req.wdata[`EXT_VOLT_CHANGE_ENABLE_EN_BIT];
            end
            if (wr_delta)
            begin
                delta_q <= sfr_req.wdata[`EXT_VOLT_CHANGE_ENABLE_DELTA_MSB:0];
            end
            if (wr_period)
            begin
                per_q <= sfr_req.wdata[`EXT_VOLT_CHANGE_ENABLE_PER_MSB:`EXT_VOLT_CHANGE_ENABLE_PER_LSB];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            flag_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (flag_set)
            begin
                flag_q <= 1'b1;
            end
            else if (wr_flags && !sfr_req.wdata[`EXT_VOLT_CHANGE_ENABLE_FLAG_BIT])
            begin
                flag_q <= 1'b0;
            end
        end
    end

    // Result and reference move only with the converter interrupt
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            result_q <= `EXT_VOLT_CHANGE_ENABLE_RESET_BYTE;
            ref_q    <= `EXT_VOLT_CHANGE_ENABLE_RESET_BYTE;
        end
        else if (clk_en && irq_evt)
        begin
            // Raw code, one step per EXT_VOLT_CHANGE_ENABLE_LSB_UV microvolts
            result_q <= data_s;
            ref_q    <= data_s;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt outputs
    // ---------------------------------------------------------------
    // The converter interrupt is a pulse only; nothing latches it
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            adc_irq <= 1'b0;
            psm_irq <= 1'b0;
        end
        else if (clk_en)
        begin
            adc_irq <= irq_evt;
            psm_irq <= (flag_q || flag_set) && en_q;
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb
    begin
        rd_mux = `EXT_VOLT_CHANGE_ENABLE_RESET_BYTE;
        unique case (sfr_req.addr)
            `EXT_VOLT_CHANGE_ENABLE_ADDR_START:  rd_mux[`EXT_VOLT_CHANGE_ENABLE_GO_BIT] = go_q;
            `EXT_VOLT_CHANGE_ENABLE_ADDR_ENABLE: rd_mux[`EXT_VOLT_CHANGE_ENABLE_EN_BIT] = en_q;
            `EXT_VOLT_CHANGE_ENABLE_ADDR_RESULT: rd_mux = result_q;
            `EXT_VOLT_CHANGE_ENABLE_ADDR_DELTA:  rd_mux[`EXT_VOLT_CHANGE_ENABLE_DELTA_MSB:0] = delta_q;
            `EXT_VOLT_CHANGE_ENABLE_ADDR_FLAGS:  rd_mux[`EXT_VOLT_CHANGE_ENABLE_FLAG_BIT] = flag_q;
            `EXT_VOLT_CHANGE_ENABLE_ADDR_PERIOD: rd_mux[`EXT_VOLT_CHANGE_ENABLE_PER_MSB:`EXT_VOLT_CHANGE_ENABLE_PER_LSB] = per_q;
            default:            rd_mux = `EXT_VOLT_CHANGE_ENABLE_RESET_BYTE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sfr_rdata <= `EXT_VOLT_CHANGE_ENABLE_RESET_BYTE;
        end
        else if (clk_en && sfr_req.rd)
        begin
            sfr_rdata <= rd_mux;
        end
    end

endmodule : ext_volt_change_enable_ctrl

// ### tb/ext_volt_change_enable_checker.sv
`timescale 1ns/1ps

module ext_volt_change_enable_checker
    import ext_volt_change_enable_pkg::*;
(
    // Clock and reset
    input wire logic           core_clk,
    input wire logic           reset_n,
    input wire logic           clk_en,
    // Register access
    input wire ext_volt_change_enable_sfr_req_t sfr_req,
    input wire logic [7:0]     sfr_rdata,
    input wire ext_volt_change_enable_pwr_t     pwr_mode_in,
    // Converter and interrupts
    input wire logic           conv_req,
    input wire logic           conv_done_in,
    input wire ext_volt_change_enable_code_t    conv_data_in,
    input wire logic           adc_irq,
    input wire logic           psm_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // Config seen since reset
    // ----------------------------------------
    logic seen_q;
    wire  cfg_wr = sfr_req.wr && sfr_req.addr inside {8'hd8, 8'hf9};
    wire  psm_wr = sfr_req.wr && sfr_req.addr inside {8'hec, 8'hf8};
    always_ff @(posedge core_clk or negedge reset_n)
        if (!reset_n) seen_q <= 1'b0;
        else if (cfg_wr) seen_q <= 1'b1;

    property p_irq_pulse; adc_irq |=> !adc_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("converter irq wider than one cycle");
    property p_irq_end;
        adc_irq |-> $fell(conv_req) && $past(conv_done_in, 2);
    endproperty
    a_irq_end: assert property (p_irq_end)
        else $error("irq without finished conversion");
    property p_req_fall; $fell(conv_req) |-> $past(conv_done_in, 2);
    endproperty
    a_req_fall: assert property (p_req_fall)
        else $error("request dropped before result");
    property p_req_rise; $rose(conv_req) |-> !conv_done_in; endproperty
    a_req_rise: assert property (p_req_rise)
        else $error("request while converter still done");
    property p_req_hold; conv_req && !conv_done_in |=> conv_req;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request released early");
    property p_no_bg; conv_req |-> seen_q; endproperty
    a_no_bg: assert property (p_no_bg)
        else $error("conversion before any setup");
    property p_psm_rise;
        $rose(psm_irq) |-> adc_irq || $past(psm_wr)
            || $past(psm_wr, 2);
    endproperty
    a_psm_rise: assert property (p_psm_rise)
        else $error("power irq rose without cause");
    property p_psm_fall;
        $fell(psm_irq) |-> $past(psm_wr) || $past(psm_wr, 2);
    endproperty
    a_psm_fall: assert property (p_psm_fall)
        else $error("power irq fell without write");
    property p_rd_hold; !$past(sfr_req.rd) |-> $stable(sfr_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without read");
endmodule : ext_volt_change_enable_checker

bind ext_volt_change_enable_ctrl ext_volt_change_enable_checker u_chk (.core_clk, .reset_n, .clk_en,
    .sfr_req, .sfr_rdata, .pwr_mode_in, .conv_req, .conv_done_in,
    .conv_data_in, .adc_irq, .psm_irq);

// ### tb/ext_volt_change_enable_conv_model.sv
`timescale 1ns/1ps

module ext_volt_change_enable_conv_model
    import ext_volt_change_enable_pkg::*;
(
    // Clock
    input wire logic        clk,
    // Handshake
    input wire logic        conv_req,
    input wire logic [7:0]  lat,
    input wire ext_volt_change_enable_code_t code,
    output logic            done,
    output ext_volt_change_enable_code_t     data
);
    logic [7:0] cnt_q = 8'h00;
    initial done = 1'b0;
    initial data = 8'ha5;

    // Released data shows the inverse so stale codes never match
    always @(posedge clk)
    begin
        if (done && !conv_req)
        begin
            done <= 1'b0;
            data <= ~data;
        end
        else if (!done && conv_req && cnt_q >= lat)
        begin
            done  <= 1'b1;
            data  <= code;
            cnt_q <= 8'h00;
        end
        else if (!done && conv_req)
            cnt_q <= cnt_q + 8'h01;
    end
endmodule : ext_volt_change_enable_conv_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "ext_volt_change_enable_params.svh"

module tb_top
    import ext_volt_change_enable_pkg::*;
;
    localparam int P1 = 64;
    logic           core_clk = 1'b0;
    logic           reset_n = 1'b0;
    ext_volt_change_enable_sfr_req_t sfr_req = '0;
    ext_volt_change_enable_pwr_t     pwr = 3'b100;
    logic           req, done, airq, pirq;
    logic           req_d = 1'b0;
    ext_volt_change_enable_code_t    data, rdata;
    ext_volt_change_enable_code_t    code = 8'h00;
    ext_volt_change_enable_code_t    ref_v = 8'h00;
    logic [7:0]     lat = 8'h03;
    logic [31:0]    seed = 32'h81d8963e;
    int             error_cnt = 0;
    int             cmp_count = 0;
    int             rises = 0;
    logic [7:0]     adr [7] = '{8'hd8, 8'hec, 8'hef, 8'hf3, 8'hf8,
                                8'hf9, 8'h42};
    logic [7:0]     msk [7] = '{8'h00, 8'h08, 8'h00, 8'h07, 8'h00,
                                8'h30, 8'h00};

    always #4 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        req_d <= req;
        if (req && !req_d) rises <= rises + 1;
    end

    ext_volt_change_enable_ctrl #(.PER1_CYC(32'd64), .PER2_CYC(32'd128),
        .PER3_CYC(32'd256)) uut (.core_clk, .reset_n, .clk_en(1'b1),
        .sfr_req, .sfr_rdata(rdata), .pwr_mode_in(pwr), .conv_req(req),
        .conv_done_in(done), .conv_data_in(data), .adc_irq(airq),
        .psm_irq(pirq));
    ext_volt_change_enable_conv_model model (.clk(core_clk), .conv_req(req), .lat,
        .code, .done, .data);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr

    function automatic logic over(input logic [7:0] a, b,
                                  input logic [2:0] d);
        return ((a > b) ? a - b : b - a) > {5'h00, d};
    endfunction : over

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t %s %h/%h", $time, m, got, exp);
            error_cnt++;
        end
    endtask : chk

    task automatic acc(input logic w, input logic [7:0] a, d);
        @(negedge core_clk);
        sfr_req = '{w, !w, a, d};
        @(negedge core_clk);
        sfr_req = '0;
    endtask : acc

    task automatic rd(input logic [7:0] a, e, input string m);
        acc(1'b0, a, 8'h00);
        chk(rdata, e, m);
    endtask : rd

    task automatic wait_irq(input int n, output logic got);
        got = 1'b0;
        repeat (n)
        begin
            @(negedge core_clk);
            if (airq === 1'b1)
            begin
                got = 1'b1;
                break;
            end
        end
    endtask : wait_irq

    task automatic single(input logic [7:0] c, input string m);
        logic g;
        code = c;
        acc(1'b1, `EXT_VOLT_CHANGE_ENABLE_ADDR_START, 8'h04);
        wait_irq(200, g);
        chk({7'h00, g}, 8'h01, m);
        rd(`EXT_VOLT_CHANGE_ENABLE_ADDR_RESULT, c, m);
        rd(`EXT_VOLT_CHANGE_ENABLE_ADDR_START, 8'h00, m);
        ref_v = c;
    endtask : single

    task automatic gap(output int c);
        for (int k = 0; k < 2; k++)
        begin
            int n;
            n = rises;
            c = 0;
            while (rises == n && c < 600)
            begin
                @(negedge core_clk);
                c++;
            end
        end
    endtask : gap

    initial
    begin : wdog
        #(8 * 20000);
        error_cnt++;
        give_verdict();
    end

    initial
    begin : main
        logic g;
        logic e;
        int   c;
        int   n;
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        foreach (adr[i]) rd(adr[i], 8'h00, "reset");
        for (int i = 1; i < 7; i++)
        begin
            acc(1'b1, adr[i], 8'hff);
            rd(adr[i], msk[i], "access");
            acc(1'b1, adr[i], 8'h00);
        end
        $display("test registers done");
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            lat = {4'h0, seed[11:8]};
            single(seed[7:0], "single");
        end
        $display("test single done");
        acc(1'b1, `EXT_VOLT_CHANGE_ENABLE_ADDR_DELTA, 8'h04);
        acc(1'b1, `EXT_VOLT_CHANGE_ENABLE_ADDR_PERIOD, 8'h10);
        for (int i = 0; i < 12; i++)
        begin
            seed = lfsr(seed);
            acc(1'b1, `EXT_VOLT_CHANGE_ENABLE_ADDR_ENABLE, {4'h0, i[0], 3'h0});
            code = (i < 4) ? ref_v + 8'(i + 3) : seed[7:0];
            e = over(code, ref_v, 3'd4);
            wait_irq(2 * P1 + 40, g);
            chk({7'h00, g}, {7'h00, e}, "bg irq");
            if (e)
            begin
                @(negedge core_clk);
                chk({7'h00, pirq}, {7'h00, i[0]}, "psm");
                rd(`EXT_VOLT_CHANGE_ENABLE_ADDR_FLAGS, 8'h08, "flag");
                ref_v = code;
                acc(1'b1, `EXT_VOLT_CHANGE_ENABLE_ADDR_FLAGS, 8'h00);
                rd(`EXT_VOLT_CHANGE_ENABLE_ADDR_FLAGS, 8'h00, "clear");
            end
            rd(`EXT_VOLT_CHANGE_ENABLE_ADDR_RESULT, ref_v, "result");
        end
        $display("test background done");
        acc(1'b1, `EXT_VOLT_CHANGE_ENABLE_ADDR_DELTA, 8'h07);
        code = ref_v;
        for (int k = 1; k < 4; k++)
        begin
            acc(1'b1, `EXT_VOLT_CHANGE_ENABLE_ADDR_PERIOD, 8'(k << 4));
            gap(c);
            chk({7'h00, c == (32 << k)}, 8'h01, "period");
        end
        $display("test interval done");
        pwr = 3'b010;
        acc(1'b1, `EXT_VOLT_CHANGE_ENABLE_ADDR_PERIOD, 8'h10);
        repeat (20) @(negedge core_clk);
        n = rises;
        repeat (300) @(negedge core_clk);
        chk({7'h00, rises == n}, 8'h01, "battery bg");
        single(ref_v ^ 8'h80, "battery go");
        pwr = 3'b001;
        acc(1'b1, `EXT_VOLT_CHANGE_ENABLE_ADDR_PERIOD, 8'h00);
        acc(1'b1, `EXT_VOLT_CHANGE_ENABLE_ADDR_START, 8'h04);
        repeat (20) @(negedge core_clk);
        n = rises;
        repeat (200) @(negedge core_clk);
        chk({7'h00, rises == n}, 8'h01, "sleep go");
        code = ref_v ^ 8'h40;
        acc(1'b1, `EXT_VOLT_CHANGE_ENABLE_ADDR_PERIOD, 8'h10);
        wait_irq(200, g);
        chk({7'h00, g}, 8'h01, "sleep bg");
        rd(`EXT_VOLT_CHANGE_ENABLE_ADDR_RESULT, code, "sleep res");
        rd(`EXT_VOLT_CHANGE_ENABLE_ADDR_START, 8'h04, "pending");
        pwr = 3'b100;
        wait_irq(200, g);
        chk({7'h00, g}, 8'h01, "full go");
        rd(`EXT_VOLT_CHANGE_ENABLE_ADDR_START, 8'h00, "go clr");
        $display("test power done");
        give_verdict();
    end
endmodule : tb_top
